// *** mpsc_asserts.sv ***
// checker: power-state controller port relations
`timescale 1ns/1ns
`default_nettype none
module mpsc_asserts
   import mpsc_pkg::*;
#(
   parameter int NIRQ = 32
)(
   input wire logic                    core_clk,
   input wire logic                    rst,
   input wire logic [2:0]              sw_req,
   input wire logic                    wait_for_interrupt_instr,
   input wire logic [NIRQ-1:0]         irq,
   input wire logic [NIRQ-1:0]         irq_wake_en,
   input wire logic [3:0]              power_state,
   input wire logic [7:0]              cpu_max_mhz,
   input wire logic [GENERAL_PINS-1:0] general_pin_en,
   input wire logic [PERIPH_PINS-1:0]  peripheral_domain_pins_en,
   input wire logic [BATTERY_PINS-1:0] battery_domain_pins_en,
   input wire logic                    periph_cfg_reset,
   input wire logic                    req_rejected
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire in_act;
   wire in_slp;
   wire in_qt;
   wire in_low;
   assign in_act = power_state inside {full_power_active,
      reduced_voltage_active, low_voltage_active};
   assign in_slp = power_state inside {full_power_sleep,
      reduced_voltage_sleep, low_voltage_sleep, shutdown_state};
   // waits, sleeps and shutdown: the states only an armed irq may leave
   assign in_qt = in_slp || power_state inside {full_power_clock_gated_wait,
      reduced_voltage_clock_gated_wait, low_voltage_clock_gated_wait};
   assign in_low = power_state inside {low_voltage_active,
      cpu_gated_peripheral_state};
   // enables count as they stood when low power was entered
   logic [NIRQ-1:0] armed_q;
   always_ff @(posedge core_clk)
   begin
      if (in_act)
         armed_q <= irq_wake_en;
   end
   chk_reset_full_state: assert property ($fell(rst) |->
      power_state == full_power_active && cpu_max_mhz == FULL_MAX_MHZ)
      else $error("state after reset is not full power");
   chk_full_pins_all: assert property (
      power_state == full_power_active |-> &general_pin_en &&
      &peripheral_domain_pins_en && &battery_domain_pins_en)
      else $error("full power pins not all enabled");
   chk_low_pins_only: assert property (in_low |-> general_pin_en == '0 &&
      &peripheral_domain_pins_en && &battery_domain_pins_en)
      else $error("low power pin set wrong");
   chk_sleep_battery_only: assert property (in_slp |->
      general_pin_en == '0 && peripheral_domain_pins_en == '0 &&
      &battery_domain_pins_en)
      else $error("sleep pin set wrong");
   chk_no_hw_entry: assert property (in_act && sw_req == REQ_NONE &&
      !wait_for_interrupt_instr |=> !in_qt &&
      power_state != cpu_gated_peripheral_state)
      else $error("low power entered without request");
   chk_armed_wake_only: assert property (in_qt &&
      (irq & armed_q) == '0 |=> $stable(power_state))
      else $error("left low power without armed irq");
   chk_shutdown_source: assert property (power_state == shutdown_state &&
      $past(power_state) != shutdown_state |->
      $past(power_state) == full_power_active)
      else $error("shutdown entered from wrong state");
   chk_gate_source: assert property (
      power_state == cpu_gated_peripheral_state &&
      $past(power_state) != cpu_gated_peripheral_state |->
      $past(power_state) == low_voltage_active)
      else $error("gated state entered from wrong state");
   chk_sleep_cfg_reset: assert property ($past(in_slp) && in_act |->
      periph_cfg_reset)
      else $error("no config reset on leaving sleep");
   chk_reject_holds: assert property (req_rejected |->
      $stable(power_state))
      else $error("state moved on a refused request");
   chk_reduced_limit: assert property (
      power_state == reduced_voltage_active |->
      cpu_max_mhz == REDUCED_MAX_MHZ)
      else $error("reduced clock limit wrong");
   cover property (power_state == reduced_voltage_sleep);
   cover property (power_state == cpu_gated_peripheral_state);
   cover property (req_rejected);
endmodule
bind mpsc_power_state_ctrl mpsc_asserts #(.NIRQ(NIRQ)) i_chk (.core_clk,
   .rst, .sw_req, .wait_for_interrupt_instr, .irq, .irq_wake_en,
   .power_state, .cpu_max_mhz, .general_pin_en, .peripheral_domain_pins_en,
   .battery_domain_pins_en, .periph_cfg_reset, .req_rejected);
`default_nettype wire

// *** mpsc_pkg.sv ***
// package: power-state controller constants and state encoding
package mpsc_pkg;
   typedef enum logic [3:0] {
      full_power_active,
      reduced_voltage_active,
      low_voltage_active,
      cpu_gated_peripheral_state,
      shutdown_state,
      full_power_clock_gated_wait,
      reduced_voltage_clock_gated_wait,
      low_voltage_clock_gated_wait,
      full_power_sleep,
      reduced_voltage_sleep,
      low_voltage_sleep
   } mpsc_state_e;

   // software request codes
   localparam logic [2:0] REQ_NONE       = 3'h0;
   localparam logic [2:0] REQ_TO_FULL    = 3'h1;
   localparam logic [2:0] REQ_TO_REDUCED = 3'h2;
   localparam logic [2:0] REQ_TO_LOW     = 3'h3;
   localparam logic [2:0] REQ_GATE_CPU   = 3'h4;
   localparam logic [2:0] REQ_SLEEP      = 3'h5;
   localparam logic [2:0] REQ_SHUTDOWN   = 3'h6;

   // processor clock limits in MHz
   localparam logic [7:0] FULL_MAX_MHZ    = 8'hB4;
   localparam logic [7:0] REDUCED_MAX_MHZ = 8'h5A;
   localparam logic [7:0] LOW_075_MAX_MHZ = 8'h14;
   localparam logic [7:0] LOW_105_MAX_MHZ = 8'h20;

   // pin counts
   localparam int GENERAL_PINS    = 30;
   localparam int PERIPH_PINS     = 10;
   localparam int BATTERY_PINS    = 3;
   localparam int TOTAL_PINS      = GENERAL_PINS + PERIPH_PINS + BATTERY_PINS;

   // sram domains
   localparam int MAIN_DOMAINS    = 10;
   localparam int PERIPH_DOMAINS  = 4;
   localparam int MAIN_BANKS      = 23;
   localparam int PERIPH_DOMAIN_KB = 2;
   localparam int BACKUP_BYTES    = 32;

   // main sram domain sizes in KB and bank counts, index 0 first
   localparam int MAIN_KB   [MAIN_DOMAINS] = '{4, 4, 4, 4, 16, 32, 64, 64,
                                               64, 64};
   localparam int MAIN_NBANK[MAIN_DOMAINS] = '{1, 1, 1, 1, 1, 2, 4, 4, 4, 4};
   localparam int MAIN_BANK0[MAIN_DOMAINS] = '{0, 1, 2, 3, 4, 5, 7, 11,
                                               15, 19};

   // wakeup latencies
   localparam int CLK_MHZ          = 100;
   localparam int FULL_WAKE_US_X10 = 12000;
   localparam int LOW_WAKE_US      = 200;
   localparam int FULL_WAKE_CYC    = FULL_WAKE_US_X10 * CLK_MHZ / 10;
   localparam int LOW_WAKE_CYC     = LOW_WAKE_US * CLK_MHZ;
   localparam int REDUCED_WAKE_CYC = FULL_WAKE_CYC;
   localparam int WAKE_CNT_W       = 18;
endpackage

// *** mpsc_power_state_ctrl.sv ***
// top: processor subsystem power-state sequencer
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - after reset enter full power active
// - only software requests move down from active
// - exits by software-enabled wakeup interrupts; gated state also by periph_irq
// - wake returns to the entering active level
// - full power allows 180 MHz, everything on
// - full power enables 30+10+3 pins
// - reduced voltage limits clock to 90 MHz
// - low voltage limit 20 or 32 MHz
// - low voltage and gated: 13 pins usable
// - wake latency 1.2 ms full, 200 us low
// - cpu gated entry only from low voltage
// - gated state: irq wakes, periph_done triggers sleep
// - gated: main sram retained, periph sram live
// - wait instruction enters matching clock-gated wait
// - upper waits wake on any armed irq, low restricted
// - each upper active level has own sleep
// - sleeps and shutdown keep battery pins only
// - leaving sleep resets peripheral configuration
// - shutdown only from full power, srams lost
// - sleeps and gated retain enabled domains, main banks per main_bank_ret
// - main sram has ten sized domains
// - periph sram four 2 KB domains
// - unused domains off, retention per bank
module mpsc_power_state_ctrl
   import mpsc_pkg::*;
#(
   parameter int FULL_WAKE    = FULL_WAKE_CYC,
   parameter int REDUCED_WAKE = REDUCED_WAKE_CYC,
   parameter int LOW_WAKE     = LOW_WAKE_CYC,
   parameter int NIRQ         = 32
)(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic [2:0]               sw_req,
   input  wire logic                     wait_for_interrupt_instr,
   input  wire logic                     low_supply_sc,
   input  wire logic                     supplies_set,
   input  wire logic [NIRQ-1:0]          irq,
   input  wire logic [NIRQ-1:0]          irq_wake_en,
   input  wire logic [NIRQ-1:0]          restricted_src,
   input  wire logic                     periph_irq,
   input  wire logic                     periph_done,
   input  wire logic [MAIN_DOMAINS-1:0]  main_dom_en,
   input  wire logic [MAIN_BANKS-1:0]    main_bank_ret,
   input  wire logic [PERIPH_DOMAINS-1:0] periph_dom_en,
   output logic      [3:0]               power_state,
   output logic                          cpu_clk_en,
   output logic                          cpu_power_en,
   output logic                          fast_clock_synth_sel,
   output logic      [7:0]               cpu_max_mhz,
   output logic      [GENERAL_PINS-1:0]  general_pin_en,
   output logic      [PERIPH_PINS-1:0]   peripheral_domain_pins_en,
   output logic      [BATTERY_PINS-1:0]  battery_domain_pins_en,
   output logic                          fast_periph_en,
   output logic                          periph_cfg_reset,
   output logic                          waking,
   output logic                          req_rejected,
   output logic      [MAIN_DOMAINS-1:0]  main_dom_pwr,
   output logic      [MAIN_BANKS-1:0]    main_bank_retain,
   output logic      [MAIN_BANKS-1:0]    main_bank_access,
   output logic      [PERIPH_DOMAINS-1:0] periph_dom_pwr,
   output logic      [PERIPH_DOMAINS-1:0] periph_dom_access
);
   mpsc_state_e           state_q;
   mpsc_state_e           state_d;
   mpsc_state_e           home_q;
   mpsc_state_e           home_d;
   logic [WAKE_CNT_W-1:0] wake_cnt_q;
   logic [WAKE_CNT_W-1:0] wake_cnt_d;
   logic [NIRQ-1:0]       armed_q;
   logic                  reject_d;

   // wakeup enables are latched at entry so a later change cannot wake
   wire any_enabled  = |(irq & armed_q);
   wire low_wakeable = |(irq & armed_q & restricted_src);
   wire is_active    = (state_q == full_power_active) ||
                       (state_q == reduced_voltage_active) ||
                       (state_q == low_voltage_active);
   wire in_wait      = (state_q == full_power_clock_gated_wait) ||
                       (state_q == reduced_voltage_clock_gated_wait) ||
                       (state_q == low_voltage_clock_gated_wait);
   wire in_sleep     = (state_q == full_power_sleep) ||
                       (state_q == reduced_voltage_sleep) ||
                       (state_q == low_voltage_sleep);
   wire in_low_power = in_wait | in_sleep |
                       (state_q == cpu_gated_peripheral_state) |
                       (state_q == shutdown_state);
   wire wake_busy    = (wake_cnt_q != '0);
   wire lose_all     = (state_q == shutdown_state);
   wire keep_periph  = (state_q == cpu_gated_peripheral_state);

   mpsc_state_e sleep_of;
   mpsc_state_e wait_of;
   always_comb
   begin
      sleep_of = full_power_sleep;
      wait_of  = full_power_clock_gated_wait;
      unique case (state_q)
         reduced_voltage_active:
         begin
            sleep_of = reduced_voltage_sleep;
            wait_of  = reduced_voltage_clock_gated_wait;
         end
         low_voltage_active:
         begin
            sleep_of = low_voltage_sleep;
            wait_of  = low_voltage_clock_gated_wait;
         end
         default:
         begin
            sleep_of = full_power_sleep;
            wait_of  = full_power_clock_gated_wait;
         end
      endcase
   end

   function automatic logic [WAKE_CNT_W-1:0] wake_len(input mpsc_state_e s);
      unique case (s)
         full_power_active:      return WAKE_CNT_W'(FULL_WAKE);
         reduced_voltage_active: return WAKE_CNT_W'(REDUCED_WAKE);
         default:                return WAKE_CNT_W'(LOW_WAKE);
      endcase
   endfunction

   always_comb
   begin
      state_d    = state_q;
      home_d     = home_q;
      wake_cnt_d = wake_busy ? wake_cnt_q - 1'b1 : wake_cnt_q;
      reject_d   = 1'b0;
      if (is_active && !wake_busy)
      begin
         // only software moves the state downward
         if (wait_for_interrupt_instr)
         begin
            state_d = wait_of;
            home_d  = state_q;
         end
         else
         begin
            unique case (sw_req)
               REQ_NONE:
               begin
               end
               REQ_TO_FULL:
                  state_d = full_power_active;
               REQ_TO_REDUCED:
                  state_d = reduced_voltage_active;
               REQ_TO_LOW:
                  // supplies must be chosen first
                  if (supplies_set)
                     state_d = low_voltage_active;
                  else
                     reject_d = 1'b1;
               REQ_GATE_CPU:
                  if (state_q == low_voltage_active)
                  begin
                     state_d = cpu_gated_peripheral_state;
                     home_d  = low_voltage_active;
                  end
                  else
                     reject_d = 1'b1;
               REQ_SLEEP:
               begin
                  state_d = sleep_of;
                  home_d  = state_q;
               end
               REQ_SHUTDOWN:
                  if (state_q == full_power_active)
                     state_d = shutdown_state;
                  else
                     reject_d = 1'b1;
               default:
                  reject_d = 1'b1;
            endcase
         end
      end
      else if (in_wait)
      begin
         // upper waits take any armed irq, low wait a restricted set
         if ((state_q == low_voltage_clock_gated_wait) ? low_wakeable
                                                       : any_enabled)
         begin
            state_d    = home_q;
            wake_cnt_d = wake_len(home_q);
         end
      end
      else if (in_sleep || state_q == shutdown_state)
      begin
         if (any_enabled)
         begin
            // shutdown restarts at full power, as after reset
            state_d    = in_sleep ? home_q : full_power_active;
            wake_cnt_d = wake_len(state_d);
         end
      end
      else if (state_q == cpu_gated_peripheral_state)
      begin
         // peripheral irq wakes; finished work goes to sleep
         if (periph_irq || any_enabled)
         begin
            state_d    = low_voltage_active;
            wake_cnt_d = wake_len(low_voltage_active);
         end
         else if (periph_done)
         begin
            state_d = low_voltage_sleep;
            home_d  = low_voltage_active;
         end
      end
   end

   wire leaving_sleep = (in_sleep || lose_all) && (state_d != state_q);

   wire [7:0] max_mhz_d =
      (state_d == full_power_active)      ? FULL_MAX_MHZ :
      (state_d == reduced_voltage_active) ? REDUCED_MAX_MHZ :
      (state_d == low_voltage_active)     ?
         (low_supply_sc ? LOW_105_MAX_MHZ : LOW_075_MAX_MHZ) :
      8'h00;
   wire full_pins_d  = (state_d == full_power_active) ||
                       (state_d == reduced_voltage_active) ||
                       (state_d == full_power_clock_gated_wait) ||
                       (state_d == reduced_voltage_clock_gated_wait);
   wire periph_pins_d = full_pins_d ||
                        (state_d == low_voltage_active) ||
                        (state_d == low_voltage_clock_gated_wait) ||
                        (state_d == cpu_gated_peripheral_state);
   wire cpu_pwr_d    = !((state_d == cpu_gated_peripheral_state) ||
                         (state_d == shutdown_state) ||
                         (state_d == full_power_sleep) ||
                         (state_d == reduced_voltage_sleep) ||
                         (state_d == low_voltage_sleep));
   wire cpu_clk_d    = (state_d == full_power_active) ||
                       (state_d == reduced_voltage_active) ||
                       (state_d == low_voltage_active);
   wire fast_sel_d   = full_pins_d;
   wire in_lp_d      = !cpu_clk_d && (state_d != full_power_clock_gated_wait)
                       && (state_d != reduced_voltage_clock_gated_wait)
                       && (state_d != low_voltage_clock_gated_wait);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q    <= full_power_active;
         home_q     <= full_power_active;
         wake_cnt_q <= '0;
         armed_q    <= '0;
      end
      else
      begin
         state_q    <= state_d;
         home_q     <= home_d;
         wake_cnt_q <= wake_cnt_d;
         // enables are captured while active, frozen once asleep
         armed_q    <= in_low_power ? armed_q : irq_wake_en;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         power_state               <= 4'h0;
         cpu_clk_en                <= 1'b1;
         cpu_power_en              <= 1'b1;
         fast_clock_synth_sel      <= 1'b1;
         cpu_max_mhz               <= FULL_MAX_MHZ;
         general_pin_en            <= '1;
         peripheral_domain_pins_en <= '1;
         battery_domain_pins_en    <= '1;
         fast_periph_en            <= 1'b1;
         periph_cfg_reset          <= 1'b0;
         waking                    <= 1'b0;
         req_rejected              <= 1'b0;
      end
      else
      begin
         power_state               <= state_d;
         cpu_clk_en                <= cpu_clk_d;
         cpu_power_en              <= cpu_pwr_d;
         fast_clock_synth_sel      <= fast_sel_d;
         cpu_max_mhz               <= max_mhz_d;
         general_pin_en            <= {GENERAL_PINS{full_pins_d}};
         peripheral_domain_pins_en <= {PERIPH_PINS{periph_pins_d}};
         battery_domain_pins_en    <= '1;
         fast_periph_en            <= full_pins_d;
         periph_cfg_reset          <= leaving_sleep;
         waking                    <= (wake_cnt_d != '0);
         req_rejected              <= reject_d;
      end
   end

   mpsc_sram_power u_sram
   (
      .core_clk          (core_clk),
      .rst               (rst),
      .low_power         (in_lp_d),
      .lose_srams        (state_d == shutdown_state),
      .main_dom_en       (main_dom_en),
      .main_bank_ret     (main_bank_ret),
      .periph_dom_en     (periph_dom_en),
      .periph_keep_live  (keep_periph || state_d ==
                          cpu_gated_peripheral_state),
      .main_dom_pwr      (main_dom_pwr),
      .main_bank_retain  (main_bank_retain),
      .main_bank_access  (main_bank_access),
      .periph_dom_pwr    (periph_dom_pwr),
      .periph_dom_access (periph_dom_access)
   );
endmodule
`default_nettype wire

// *** mpsc_sram_power.sv ***
// sram power domain and per-bank retention control
`timescale 1ns/1ns
`default_nettype none
module mpsc_sram_power
   import mpsc_pkg::*;
#(
   parameter int NMAIN   = MAIN_DOMAINS,
   parameter int NPERIPH = PERIPH_DOMAINS,
   parameter int NBANKS  = MAIN_BANKS
)(
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               low_power,
   input  wire logic               lose_srams,
   input  wire logic [NMAIN-1:0]   main_dom_en,
   input  wire logic [NBANKS-1:0]  main_bank_ret,
   input  wire logic [NPERIPH-1:0] periph_dom_en,
   input  wire logic               periph_keep_live,
   output logic      [NMAIN-1:0]   main_dom_pwr,
   output logic      [NBANKS-1:0]  main_bank_retain,
   output logic      [NBANKS-1:0]  main_bank_access,
   output logic      [NPERIPH-1:0] periph_dom_pwr,
   output logic      [NPERIPH-1:0] periph_dom_access
);
   logic [NMAIN-1:0]   main_pwr_d;
   logic [NBANKS-1:0]  ret_d;
   logic [NBANKS-1:0]  acc_d;
   logic [NPERIPH-1:0] per_pwr_d;
   logic [NPERIPH-1:0] per_acc_d;

   genvar g;
   generate
      for (g = 0; g < NMAIN; g++)
      begin : g_main
         // unused domains lose contents; shutdown loses all
         assign main_pwr_d[g] = main_dom_en[g] & ~lose_srams;
      end
      for (g = 0; g < NBANKS; g++)
      begin : g_bank
         // retention is per bank; retained banks are not accessible
         assign ret_d[g] = low_power & ~lose_srams & main_bank_ret[g];
         assign acc_d[g] = ~low_power;
      end
      for (g = 0; g < NPERIPH; g++)
      begin : g_per
         // each 2 KB single-bank domain is powered separately
         assign per_pwr_d[g] = periph_dom_en[g] & ~lose_srams;
         assign per_acc_d[g] = per_pwr_d[g] & (~low_power | periph_keep_live);
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         main_dom_pwr      <= '1;
         main_bank_retain  <= '0;
         main_bank_access  <= '1;
         periph_dom_pwr    <= '1;
         periph_dom_access <= '1;
      end
      else
      begin
         main_dom_pwr      <= main_pwr_d;
         main_bank_retain  <= ret_d & main_bank_pwr(main_pwr_d);
         main_bank_access  <= acc_d & main_bank_pwr(main_pwr_d);
         periph_dom_pwr    <= per_pwr_d;
         periph_dom_access <= per_acc_d;
      end
   end

   // expand domain power onto the banks that make it up
   function automatic logic [NBANKS-1:0] main_bank_pwr(
      input logic [NMAIN-1:0] dom);
      logic [NBANKS-1:0] b;
      b = '0;
      for (int d = 0; d < NMAIN; d++)
         for (int k = 0; k < MAIN_NBANK[d]; k++)
            b[MAIN_BANK0[d] + k] = dom[d];
      return b;
   endfunction
endmodule
`default_nettype wire

// *** mpsc_wake_src.sv ***
// partner: wakeup event source, fires one irq line on command
`timescale 1ns/1ns
`default_nettype none
module mpsc_wake_src (
   input  wire logic       core_clk,
   input  wire logic       fire,
   input  wire logic [4:0] sel,
   input  wire logic [7:0] dly,
   output var  logic [31:0] irq
);
   int cnt = -1;
   initial irq = '0;
   // raises only the line the bench names; dly sets prompt or slow
   always @(posedge core_clk)
   begin
      irq <= '0;
      if (fire)
         cnt <= int'(dly);
      else if (cnt > 0)
         cnt <= cnt - 1;
      else if (cnt == 0)
      begin
         irq[sel] <= 1'b1;
         cnt <= -1;
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// testbench: power-state controller sequences
`timescale 1ns/1ns
`default_nettype none
module tb;
   import mpsc_pkg::*;
   logic core_clk = 0, rst = 1, wait_for_interrupt_instr = 0, fire = 0;
   logic low_supply_sc = 0, supplies_set = 0, periph_done = 0, cfg_seen;
   logic periph_irq = 0, fast_clock_synth_sel, fast_periph_en;
   logic [2:0]  sw_req = REQ_NONE;
   logic [4:0]  sel = '0;
   logic [31:0] irq, irq_wake_en = 32'h3, restricted_src = 32'h1;
   logic [3:0]  power_state, periph_dom_access, periph_dom_pwr;
   logic [7:0]  cpu_max_mhz;
   logic [9:0]  main_dom_en = 10'h3FF, main_dom_pwr;
   logic [29:0] general_pin_en;
   logic [9:0]  peripheral_domain_pins_en;
   logic [2:0]  battery_domain_pins_en;
   logic [22:0] main_bank_access, main_bank_retain;
   logic        cpu_clk_en, cpu_power_en, periph_cfg_reset, waking;
   logic        req_rejected;
   int n_errors = 0, compares = 0, cyc = 0;
   always #5 core_clk = ~core_clk;
   // short wake counts keep the run brief
   mpsc_power_state_ctrl #(.FULL_WAKE(20), .REDUCED_WAKE(20), .LOW_WAKE(5),
      .NIRQ(32)) i_dut (.core_clk, .rst, .sw_req, .wait_for_interrupt_instr,
      .low_supply_sc, .supplies_set, .irq, .irq_wake_en, .restricted_src,
      .periph_irq, .periph_done, .main_dom_en,
      .main_bank_ret(23'h7FFFFF), .periph_dom_en(4'hF), .power_state,
      .cpu_clk_en, .cpu_power_en, .fast_clock_synth_sel, .cpu_max_mhz,
      .general_pin_en, .peripheral_domain_pins_en, .battery_domain_pins_en,
      .fast_periph_en, .periph_cfg_reset, .waking, .req_rejected,
      .main_dom_pwr, .main_bank_retain, .main_bank_access,
      .periph_dom_pwr, .periph_dom_access);
   mpsc_wake_src i_src (.core_clk, .fire, .sel, .dly(8'h2), .irq);
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic req(input logic [2:0] r, input logic w);
      @(negedge core_clk);
      sw_req = r;
      wait_for_interrupt_instr = w;
      @(negedge core_clk);
      sw_req = REQ_NONE;
      wait_for_interrupt_instr = 1'b0;
   endtask
   // fire one irq line; n >= 0 also checks the wake latency in cycles
   task automatic wake(input logic [4:0] b, input int n);
      int k;
      @(negedge core_clk);
      sel = b;
      fire = 1'b1;
      @(negedge core_clk);
      fire = 1'b0;
      k = 0;
      while (waking !== 1'b1 && k < 12)
      begin
         @(negedge core_clk);
         k++;
      end
      cfg_seen = periph_cfg_reset;
      k = 0;
      while (waking === 1'b1 && k < 99)
      begin
         @(negedge core_clk);
         k++;
      end
      if (n >= 0)
         chk(k, n);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         $display("[ERR] %0t run did not finish", $time);
         end_sim;
      end
   end
   initial
   begin
      repeat (8) @(negedge core_clk);
      rst = 0;
      main_dom_en = 10'h3FE; // domain 0 unused from here on
      chk(power_state, full_power_active);
      chk({fast_periph_en, fast_clock_synth_sel, cpu_max_mhz},
          {2'h3, FULL_MAX_MHZ});
      chk({general_pin_en, peripheral_domain_pins_en}, 40'hFFFFFFFFFF);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         req(i == 0 ? REQ_GATE_CPU : i == 1 ? 3'h7 : REQ_TO_LOW, 1'b0);
         chk({req_rejected, power_state}, 5'h10);
      end
      chk(main_dom_pwr, 10'h3FE);
      chk(main_bank_access, 23'h7FFFFE);
      $display("test refusals done");
      req(REQ_NONE, 1'b1);
      chk({cpu_clk_en, power_state}, full_power_clock_gated_wait);
      irq_wake_en = 32'h4; // too late: enables froze at entry
      wake(5'h2, -1);
      chk(power_state, full_power_clock_gated_wait);
      irq_wake_en = 32'h3;
      wake(5'h1, -1);
      chk(power_state, full_power_active);
      $display("test standby done");
      req(REQ_TO_REDUCED, 1'b0);
      chk(cpu_max_mhz, REDUCED_MAX_MHZ);
      req(REQ_SLEEP, 1'b0);
      chk(power_state, reduced_voltage_sleep);
      chk({general_pin_en, peripheral_domain_pins_en}, 40'h0);
      @(negedge core_clk);
      chk(main_bank_access, 23'h0);
      chk(main_bank_retain, 23'h7FFFFE);
      wake(5'h0, 20);
      chk({cfg_seen, power_state}, 5'h11);
      $display("test sleep done");
      supplies_set = 1'b1; // supplies chosen before low entry
      low_supply_sc = 1'b1;
      req(REQ_TO_LOW, 1'b0);
      chk({fast_periph_en, fast_clock_synth_sel, power_state, cpu_max_mhz},
          14'h220);
      chk({general_pin_en, peripheral_domain_pins_en}, 40'h3FF);
      req(REQ_SHUTDOWN, 1'b0);
      chk({req_rejected, power_state}, 5'h12);
      req(REQ_NONE, 1'b1);
      wake(5'h1, -1);
      chk(power_state, low_voltage_clock_gated_wait);
      wake(5'h0, -1);
      req(REQ_GATE_CPU, 1'b0);
      chk({cpu_power_en, power_state}, cpu_gated_peripheral_state);
      @(negedge core_clk);
      chk(periph_dom_access, 4'hF);
      periph_done = 1'b1;
      @(negedge core_clk);
      periph_done = 1'b0;
      chk(power_state, low_voltage_sleep);
      wake(5'h0, 5);
      chk({cfg_seen, power_state}, 5'h12);
      req(REQ_GATE_CPU, 1'b0);
      periph_irq = 1'b1;
      @(negedge core_clk);
      periph_irq = 1'b0;
      chk({waking, power_state}, 5'h12);
      repeat (5) @(negedge core_clk);
      $display("test low power done");
      req(REQ_TO_FULL, 1'b0);
      req(REQ_SHUTDOWN, 1'b0);
      chk({battery_domain_pins_en, power_state}, 7'h74);
      chk({main_dom_pwr, periph_dom_pwr}, 14'h0);
      wake(5'h0, 20);
      chk(power_state, full_power_active);
      $display("test shutdown done");
      end_sim;
   end
endmodule
`default_nettype wire
